// ### src/dma_engine.v
// Seven-channel transfer engine with router, arbiter and register bus
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`include "dma_consts.vh"

// What this block does
// - Seven independently configured channels, one request each
// - Any request line routes to any channel
// - Hardware trigger lines can start channel transfers
// - Arbiter uses four software priority levels
// - Equal priority: lower channel number wins
// - Byte/half/word sizes per side, pack/unpack
// - Circular mode restarts from programmed start
// - Three flags ORed into one channel interrupt
// - All four memory/peripheral transfer directions
// - Reaches flash, SRAM and both peripheral buses
// - Programmable item count, at most 65536
module dma_engine (
    input  wire                 core_clk,          // System clock
    input  wire                 arst_n,            // Async reset
    // Register slave
    input  wire [7:0]           avs_address,       // Byte address
    input  wire                 avs_read,          // Read strobe
    input  wire                 avs_write,         // Write strobe
    input  wire [31:0]          avs_writedata,     // Write data
    input  wire [3:0]           avs_byteenable,    // Lane enables
    output reg  [31:0]          avs_readdata,      // Read data
    output reg                  avs_waitrequest,   // Stall
    // Memory master
    output reg  [31:0]          avm_address,       // Word-aligned byte address
    output reg                  avm_read,          // Read strobe
    output reg                  avm_write,         // Write strobe
    output reg  [31:0]          avm_writedata,     // Write data
    output reg  [3:0]           avm_byteenable,    // Lane enables
    input  wire [31:0]          avm_readdata,      // Read data
    input  wire                 avm_waitrequest,   // Stall
    input  wire [1:0]           avm_response,      // Nonzero is error
    // Requesters
    input  wire [`NPER-1:0]     periph_req,        // Peripheral requests
    input  wire [`NTRIG-1:0]    hw_trig,           // Hardware triggers
    output reg  [`CH_NUM-1:0]   ch_irq             // Per-channel irq
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'h1;                // Waiting for grant
    localparam [2:0] S_RD   = 3'h2;                // Source read
    localparam [2:0] S_WR   = 3'h4;                // Destination write
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Lanes touched by one element at a byte offset
    function [3:0] lane_be;
        input [1:0] sz;
        input [1:0] off;
        begin
            case (sz)
                `SZ_BYTE: lane_be = 4'h1 << off;
                `SZ_HALF: lane_be = 4'h3 << off;
                default:  lane_be = 4'hf;
            endcase
        end
    endfunction
    // Low bits kept by an element of this size
    function [31:0] sz_mask;
        input [1:0] sz;
        begin
            case (sz)
                `SZ_BYTE: sz_mask = 32'h0000_00ff;
                `SZ_HALF: sz_mask = 32'h0000_ffff;
                default:  sz_mask = 32'hffff_ffff;
            endcase
        end
    endfunction
    // Merge a bus write into a register by byte lanes
    function [31:0] be_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer      k;
        begin
            be_merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    be_merge[k*8 +: 8] = nw[k*8 +: 8];
                end
            end
        end
    endfunction
    // ------------------------------------------------------------
    // Channel storage
    // ------------------------------------------------------------
    reg  [`CFG_W-1:0]    cfg_reg   [0:`CH_NUM-1];  // Configuration
    reg  [`CNT_W-1:0]    cnt_reg   [0:`CH_NUM-1];  // Programmed count
    reg  [`CNT_W-1:0]    rem_reg   [0:`CH_NUM-1];  // Remaining items
    reg  [31:0]          src_reg   [0:`CH_NUM-1];  // Source start
    reg  [31:0]          dst_reg   [0:`CH_NUM-1];  // Destination start
    reg  [31:0]          scur_reg  [0:`CH_NUM-1];  // Source pointer
    reg  [31:0]          dcur_reg  [0:`CH_NUM-1];  // Destination pointer
    reg  [`SEL_W-1:0]    sel_reg   [0:`CH_NUM-1];  // Router select
    reg  [2:0]           flg_reg   [0:`CH_NUM-1];  // HT, TC, TE
    reg  [`CH_NUM-1:0]   pend_reg;                 // Latched requests
    // Engine
    reg  [2:0]           st_reg;                   // Engine state
    reg  [2:0]           cur_reg;                  // Channel in service
    reg  [31:0]          data_reg;                 // Element in flight
    // Synchronisers for outside lines
    reg  [`NSRC-1:0]     sync1_reg;                // First stage
    reg  [`NSRC-1:0]     sync2_reg;                // Second stage
    reg  [`CH_NUM-1:0]   route_q_reg;              // Routed, delayed
    // ------------------------------------------------------------
    // Routing and arbitration
    // ------------------------------------------------------------
    wire [`CH_NUM-1:0]          route;             // Routed levels
    wire [`CH_NUM-1:0]          req_rise;          // New request
    wire                        gnt_valid;         // Winner exists
    wire [2:0]                  gnt_idx;           // Winner index
    reg  [`CH_NUM-1:0]          elig;              // Servable channels
    reg  [`CH_NUM*`SEL_W-1:0]   sel_flat;          // Packed selects
    reg  [`CH_NUM*2-1:0]        prio_flat;         // Packed priorities
    integer                     i;                 // Engine loop index
    integer                     pk;                // Packing loop index
    integer                     sk;                // Irq loop index
    assign req_rise = route & ~route_q_reg;
    // Pack per-channel fields for the sub-blocks
    always @* begin
        for (pk = 0; pk < `CH_NUM; pk = pk + 1) begin
            sel_flat[pk*`SEL_W +: `SEL_W] = sel_reg[pk];
            prio_flat[pk*2 +: 2]          = cfg_reg[pk][`CFG_PRIO];
            // Free-running when memory-to-memory, else on request
            elig[pk] = cfg_reg[pk][`CFG_EN] &&
                       (cfg_reg[pk][`CFG_M2M] || pend_reg[pk]) &&
                       (rem_reg[pk] != `CNT_RST);
        end
    end
    request_router u_router (
        .src_vec  (sync2_reg),
        .sel_flat (sel_flat),
        .route    (route)
    );
    channel_arbiter u_arb (
        .elig      (elig),
        .prio_flat (prio_flat),
        .gnt_valid (gnt_valid),
        .gnt_idx   (gnt_idx)
    );
    // ------------------------------------------------------------
    // Completion events
    // ------------------------------------------------------------
    wire                bus_err   = (avm_response != 2'h0);
    wire                rd_done   = (st_reg == S_RD) && !avm_waitrequest;
    wire                wr_done   = (st_reg == S_WR) && !avm_waitrequest;
    wire [`CNT_W-1:0]   rem_cur   = rem_reg[cur_reg];
    wire [`CNT_W-1:0]   rem_after = rem_cur - 17'h0_0001;
    wire [`CNT_W-1:0]   cnt_cur   = cnt_reg[cur_reg];
    wire [`CFG_W-1:0]   cfg_cur   = cfg_reg[cur_reg];
    wire                item_ok   = wr_done && !bus_err;
    wire                item_err  = (rd_done || wr_done) && bus_err;
    // Midpoint: items moved equals half the programmed count
    wire                hit_half  = (rem_after ==
                                     cnt_cur - (cnt_cur >> 1));
    wire                hit_zero  = (rem_after == `CNT_RST);
    // Register bus decode
    wire [2:0]          a_ch   = avs_address[7:5];
    wire [2:0]          a_reg  = avs_address[4:2];
    wire                a_hit  = (a_ch < `CH_NUM);
    wire                wr_acc = avs_write && !avs_waitrequest && a_hit;
    reg  [31:0]         rd_mux;                    // Read value
    wire [31:0]         cfg_wr = be_merge({21'h00_0000, cfg_reg[a_ch]},
                                          avs_writedata, avs_byteenable);
    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    // Unmapped windows and offsets read as zero
    always @* begin
        rd_mux = 32'h0000_0000;
        if (a_hit) begin
            case (a_reg)
                `REG_CFG: rd_mux = {21'h00_0000, cfg_reg[a_ch]};
                `REG_CNT: rd_mux = {15'h0000, rem_reg[a_ch]};
                `REG_SRC: rd_mux = src_reg[a_ch];
                `REG_DST: rd_mux = dst_reg[a_ch];
                `REG_SEL: rd_mux = {27'h000_0000, sel_reg[a_ch]};
                `REG_FLG: rd_mux = {29'h0000_0000, flg_reg[a_ch]};
                default:  rd_mux = 32'h0000_0000;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Register slave handshake
    // ------------------------------------------------------------
    // One stall cycle, then a single ready cycle; read data loads as
    // the stall drops, write effect lands on the edge that sees ready
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rd_mux;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Input synchronisers and edge history
    // ------------------------------------------------------------
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg   <= {`NSRC{1'b0}};
            sync2_reg   <= {`NSRC{1'b0}};
            route_q_reg <= {`CH_NUM{1'b0}};
            ch_irq      <= {`CH_NUM{1'b0}};
        end else begin
            sync1_reg   <= {hw_trig, periph_req};
            sync2_reg   <= sync1_reg;
            route_q_reg <= route;
            for (sk = 0; sk < `CH_NUM; sk = sk + 1) begin
                ch_irq[sk] <= |flg_reg[sk];
            end
        end
    end
    // ------------------------------------------------------------
    // Channel registers and transfer engine
    // ------------------------------------------------------------
    // One process owns all channel state so software writes and
    // engine updates never fight; engine updates come last
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < `CH_NUM; i = i + 1) begin
                cfg_reg[i]  <= `CFG_RST;
                cnt_reg[i]  <= `CNT_RST;
                rem_reg[i]  <= `CNT_RST;
                src_reg[i]  <= `ADR_RST;
                dst_reg[i]  <= `ADR_RST;
                scur_reg[i] <= `ADR_RST;
                dcur_reg[i] <= `ADR_RST;
                sel_reg[i]  <= `SEL_RST;
                flg_reg[i]  <= 3'h0;
            end
            pend_reg       <= {`CH_NUM{1'b0}};
            st_reg         <= S_IDLE;
            cur_reg        <= 3'h0;
            data_reg       <= 32'h0000_0000;
            avm_address    <= 32'h0000_0000;
            avm_read       <= 1'b0;
            avm_write      <= 1'b0;
            avm_writedata  <= 32'h0000_0000;
            avm_byteenable <= 4'h0;
        end else begin
            // Request latch: a new edge beats the grant clear
            pend_reg <= (pend_reg &
                         ~((gnt_valid && st_reg == S_IDLE) ?
                           (7'h01 << gnt_idx) : 7'h00)) | req_rise;
            // Flags: write one to clear, hardware set wins
            for (i = 0; i < `CH_NUM; i = i + 1) begin
                flg_reg[i] <= (flg_reg[i] &
                    ~((wr_acc && a_ch == i && a_reg == `REG_FLG) ?
                      avs_writedata[2:0] : 3'h0)) |
                    ((cur_reg == i) ?
                     {item_err,
                      item_ok && hit_zero,
                      item_ok && hit_half} : 3'h0);
            end

            // Software writes
            if (wr_acc) begin
                case (a_reg)
                    `REG_CFG: begin
                        cfg_reg[a_ch] <= cfg_wr[`CFG_W-1:0];
                        // Enabling reloads pointers and count
                        if (avs_byteenable[0] && avs_writedata[`CFG_EN] &&
                            !cfg_reg[a_ch][`CFG_EN]) begin
                            scur_reg[a_ch] <= src_reg[a_ch];
                            dcur_reg[a_ch] <= dst_reg[a_ch];
                            rem_reg[a_ch]  <= cnt_reg[a_ch];
                        end
                    end
                    `REG_CNT: begin
                        // Counts above the maximum are clipped
                        if (avs_writedata[16:0] > `MAX_COUNT) begin
                            cnt_reg[a_ch] <= `MAX_COUNT;
                            rem_reg[a_ch] <= `MAX_COUNT;
                        end else begin
                            cnt_reg[a_ch] <= avs_writedata[16:0];
                            rem_reg[a_ch] <= avs_writedata[16:0];
                        end
                    end
                    `REG_SRC: src_reg[a_ch] <= be_merge(src_reg[a_ch],
                                  avs_writedata, avs_byteenable);
                    `REG_DST: dst_reg[a_ch] <= be_merge(dst_reg[a_ch],
                                  avs_writedata, avs_byteenable);
                    `REG_SEL: sel_reg[a_ch] <= avs_writedata[4:0];
                    default: ;
                endcase
            end

            // Engine sequencing
            case (st_reg)
                S_IDLE: begin
                    if (gnt_valid) begin
                        cur_reg        <= gnt_idx;
                        avm_address    <= {scur_reg[gnt_idx][31:2], 2'h0};
                        avm_byteenable <= lane_be(
                            cfg_reg[gnt_idx][`CFG_SSZ],
                            scur_reg[gnt_idx][1:0]);
                        avm_read       <= 1'b1;
                        st_reg         <= S_RD;
                    end
                end
                S_RD: begin
                    if (!avm_waitrequest) begin
                        avm_read <= 1'b0;
                        if (bus_err) begin
                            cfg_reg[cur_reg][`CFG_EN] <= 1'b0;
                            st_reg <= S_IDLE;
                        end else begin
                            // Unpack source lane, pad or truncate
                            data_reg <= (avm_readdata >>
                                {scur_reg[cur_reg][1:0], 3'h0}) &
                                sz_mask(cfg_cur[`CFG_SSZ]);
                            avm_address <=
                                {dcur_reg[cur_reg][31:2], 2'h0};
                            avm_byteenable <= lane_be(cfg_cur[`CFG_DSZ],
                                dcur_reg[cur_reg][1:0]);
                            avm_writedata <= ((avm_readdata >>
                                {scur_reg[cur_reg][1:0], 3'h0}) &
                                sz_mask(cfg_cur[`CFG_SSZ]) &
                                sz_mask(cfg_cur[`CFG_DSZ])) <<
                                {dcur_reg[cur_reg][1:0], 3'h0};
                            avm_write <= 1'b1;
                            st_reg    <= S_WR;
                        end
                    end
                end
                S_WR: begin
                    if (!avm_waitrequest) begin
                        avm_write <= 1'b0;
                        st_reg    <= S_IDLE;
                        if (bus_err) begin
                            cfg_reg[cur_reg][`CFG_EN] <= 1'b0;
                        end else if (hit_zero &&
                                     cfg_cur[`CFG_CIRC]) begin
                            // Wrap to the programmed start
                            rem_reg[cur_reg]  <= cnt_cur;
                            scur_reg[cur_reg] <= src_reg[cur_reg];
                            dcur_reg[cur_reg] <= dst_reg[cur_reg];
                        end else begin
                            rem_reg[cur_reg] <= rem_after;
                            if (cfg_cur[`CFG_SINC]) begin
                                scur_reg[cur_reg] <= scur_reg[cur_reg] +
                                    (32'h0000_0001 << cfg_cur[`CFG_SSZ]);
                            end
                            if (cfg_cur[`CFG_DINC]) begin
                                dcur_reg[cur_reg] <= dcur_reg[cur_reg] +
                                    (32'h0000_0001 << cfg_cur[`CFG_DSZ]);
                            end
                        end
                    end
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end
endmodule // dma_engine

// ### src/dma_consts.vh
// Constants for the seven-channel transfer engine and its request router
`ifndef DMA_CONSTS_VH
`define DMA_CONSTS_VH

// Sizes of the engine
`define CH_NUM      7
`define NPER        16
`define NTRIG       4
`define NSRC        20
`define SEL_W       5
`define CNT_W       17
`define CFG_W       11

// Register offsets inside one channel window (byte address bits 4:2)
`define REG_CFG     3'h0
`define REG_CNT     3'h1
`define REG_SRC     3'h2
`define REG_DST     3'h3
`define REG_SEL     3'h4
`define REG_FLG     3'h5

// Configuration fields
`define CFG_EN      0
`define CFG_CIRC    1
`define CFG_PRIO    3:2
`define CFG_SSZ     5:4
`define CFG_DSZ     7:6
`define CFG_SINC    8
`define CFG_DINC    9
`define CFG_M2M     10

// Flag fields
`define FLG_HT      0
`define FLG_TC      1
`define FLG_TE      2

// Element sizes
`define SZ_BYTE     2'h0
`define SZ_HALF     2'h1
`define SZ_WORD     2'h2

// Reset values
`define CFG_RST     11'h000
`define CNT_RST     17'h0_0000
`define ADR_RST     32'h0000_0000
`define SEL_RST     5'h1f
`define MAX_COUNT   17'h1_0000

`endif

// ### src/request_router.v
// Crossbar that routes any request or trigger line to any channel
`timescale 1ns/10ps
`include "dma_consts.vh"

module request_router (
    input  wire [`NSRC-1:0]          src_vec,  // Synchronised sources
    input  wire [`CH_NUM*`SEL_W-1:0] sel_flat, // Per-channel selects
    output reg  [`CH_NUM-1:0]        route     // Routed level per channel
);
    integer                          i;
    reg     [`SEL_W-1:0]             s;

    // ------------------------------------------------------------
    // Full crossbar
    // ------------------------------------------------------------
    // Out-of-range select means the channel is left unconnected
    always @* begin
        s = {`SEL_W{1'b0}};
        for (i = 0; i < `CH_NUM; i = i + 1) begin
            s = sel_flat[i*`SEL_W +: `SEL_W];
            if (s < `NSRC) begin
                route[i] = src_vec[s];
            end else begin
                route[i] = 1'b0;
            end
        end
    end
endmodule // request_router

// ### src/channel_arbiter.v
// Priority arbiter picking one eligible channel
`timescale 1ns/10ps
`include "dma_consts.vh"

module channel_arbiter (
    input  wire [`CH_NUM-1:0]   elig,      // Channel may be served
    input  wire [`CH_NUM*2-1:0] prio_flat, // Two priority bits each
    output reg                  gnt_valid, // Some channel won
    output reg  [2:0]           gnt_idx    // Winning channel
);
    integer                     i;
    reg     [1:0]               best;

    // ------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------
    // Strictly-greater test keeps the lower index on equal levels
    always @* begin
        gnt_valid = 1'b0;
        gnt_idx   = 3'h0;
        best      = 2'h0;
        for (i = 0; i < `CH_NUM; i = i + 1) begin
            if (elig[i] && (!gnt_valid ||
                prio_flat[i*2 +: 2] > best)) begin
                gnt_valid = 1'b1;
                gnt_idx   = i[2:0];
                best      = prio_flat[i*2 +: 2];
            end
        end
    end
endmodule // channel_arbiter

// ### testbench/dma_engine_sva.sv
// Port assertions for the transfer engine
`timescale 1ns/10ps
module dma_chk (
    input wire        core_clk,
    input wire        arst_n,
    input wire        avs_read,
    input wire        avs_write,
    input wire        avs_waitrequest,
    input wire [31:0] avm_address,
    input wire        avm_read,
    input wire        avm_write,
    input wire        avm_waitrequest,
    input wire [1:0]  avm_response
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Read beat finishing this edge
    wire rd_ok = avm_read && !avm_waitrequest;
    a_reg_answer: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    a_reg_once: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("stall low too long");
    a_no_overlap: assert property (!(avm_read && avm_write))
        else $error("read and write together");
    a_read_hold: assert property (avm_read && avm_waitrequest |=>
        avm_read && $stable(avm_address)) else $error("read dropped");
    a_write_next: assert property (rd_ok && avm_response == 2'h0 |=>
        avm_write) else $error("no write after read");
    a_error_stop: assert property (rd_ok && avm_response != 2'h0 |=>
        !avm_write) else $error("write after bus error");
    a_item_gap: assert property (avm_write && !avm_waitrequest |=>
        !avm_read && !avm_write) else $error("no idle after item");
    a_word_addr: assert property ((avm_read || avm_write) |->
        avm_address[1:0] == 2'h0) else $error("unaligned bus address");
endmodule // dma_chk
bind dma_engine dma_chk u_chk (.*);

// ### testbench/mem_model.sv
// Memory slave on the engine's master bus, fast or slow
`timescale 1ns/10ps
module mem_model (
    input  wire        core_clk,
    input  wire [31:0] avm_address,
    input  wire        avm_read,
    input  wire        avm_write,
    input  wire [31:0] avm_writedata,
    input  wire [3:0]  avm_byteenable,
    input  wire [1:0]  lat,       // Stall cycles per access
    input  wire [7:0]  err_addr,  // Byte address that faults
    output wire [31:0] avm_readdata,
    output wire        avm_waitrequest,
    output wire [1:0]  avm_response
);
    reg  [31:0] mem [0:63];
    reg  [1:0]  cnt = 2'h0;
    integer     i;
    wire        fin  = (avm_read | avm_write) && cnt == lat;
    wire        bad  = fin && avm_address[7:0] == err_addr;
    wire [31:0] word = mem[avm_address[7:2]];
    assign avm_waitrequest = !fin;
    assign avm_response = bad ? 2'h2 : 2'h0;
    // Idle data lines show the inverse, never a stale word
    assign avm_readdata = fin && avm_read ? word : ~word;
    initial for (i = 0; i < 64; i++) mem[i] = 32'h4433_2200 | i;
    // Lanes land only at the completing edge, and not on a fault
    always @(posedge core_clk) begin
        cnt <= fin ? 2'h0 : cnt + {1'b0, avm_read | avm_write};
        for (i = 0; i < 4; i++)
            if (fin && avm_write && !bad && avm_byteenable[i])
                mem[avm_address[7:2]][8*i +: 8] <= avm_writedata[8*i +: 8];
    end
endmodule // mem_model

// ### testbench/testbench.sv
// Register-level tests of the seven-channel transfer engine
`timescale 1ns/10ps
module testbench;
    reg         core_clk = 0, arst_n = 0, avs_read = 0, avs_write = 0;
    reg  [7:0]  avs_address = 8'h00, err_addr = 8'hff;
    reg  [31:0] avs_writedata = 32'h0000_0000, q, log_q [$];
    reg  [3:0]  avs_byteenable = 4'hf, hw_trig = 4'h0;
    reg  [15:0] periph_req = 16'h0000;
    reg  [1:0]  lat = 2'h0;
    wire [31:0] avs_readdata, avm_address, avm_writedata, avm_readdata;
    wire [3:0]  avm_byteenable;
    wire [1:0]  avm_response;
    wire [6:0]  ch_irq;
    wire        avs_waitrequest, avm_read, avm_write, avm_waitrequest;
    integer     fail_count = 0, check_count = 0, cyc = 0, n, m;
    dma_engine dut (.*);
    mem_model mem (.*);
    initial forever #5 core_clk = ~core_clk;
    // Watchdog, and a log of every memory read address
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (avm_read && !avm_waitrequest) log_q.push_back(avm_address);
        if (cyc == 20000) begin
            fail_count++;
            complete_run;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // Op 0 reads and checks, 1 writes, 2 reads only
    task bus(input [1:0] op, input [7:0] a, input [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= op == 2'h1;
        avs_read <= op != 2'h1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (op == 2'h0) chk(q, d);
    endtask
    // Poll the flags until complete, bounded
    task wait_tc(input [2:0] c);
        q = 0;
        for (n = 0; n < 99 && q[1] !== 1'b1; n++) bus(2, {c, 5'h14}, 0);
    endtask
    // Request edge; held long enough to pass the synchroniser
    task kick(input [19:0] v);
        @(posedge core_clk) {hw_trig, periph_req} <= v;
        repeat (4) @(posedge core_clk);
        {hw_trig, periph_req} <= 20'h0_0000;
        repeat (9) @(posedge core_clk);
    endtask
    task setup(input [2:0] c, input [10:0] f, input [31:0] k,
               input [31:0] s, input [31:0] d, input [4:0] sel);
        bus(1, {c, 5'h00}, 0);
        bus(1, {c, 5'h04}, k);
        bus(1, {c, 5'h08}, s);
        bus(1, {c, 5'h0c}, d);
        bus(1, {c, 5'h10}, sel);
        bus(1, {c, 5'h14}, 7);
        bus(1, {c, 5'h00}, f);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        for (m = 0; m < 7; m++) bus(0, {m[2:0], 5'h10}, 31);
        bus(1, 8'he0, 32'hffff_ffff);
        bus(0, 8'he0, 0);
        bus(1, 8'h04, 32'h0001_ffff);
        bus(0, 8'h04, 32'h0001_0000);
        $display("test registers done");
        lat <= 2'h1;
        setup(0, 11'h7a1, 4, 0, 32'h40, 31);
        wait_tc(0);
        chk(q, 3);
        chk(ch_irq[0], 1);
        for (m = 0; m < 4; m++) chk(mem.mem[16+m], 32'h4433_2200|m);
        lat <= 2'h0;
        setup(1, 11'h481, 1, 5, 32'h80, 31);
        wait_tc(1);
        chk(mem.mem[32], 32'h0000_0022);
        setup(1, 11'h461, 1, 8, 32'h86, 31);
        wait_tc(1);
        chk(mem.mem[33], 32'h2202_2221);
        $display("test copies done");
        setup(2, 11'h0a1, 1, 32'h10, 32'hc0, 0);
        setup(3, 11'h0a1, 1, 32'h14, 32'hc0, 0);
        log_q.delete();
        kick(20'h0_0001);
        wait_tc(3);
        chk(log_q[0], 32'h10);
        setup(2, 11'h0a1, 1, 32'h10, 32'hc0, 16);
        setup(3, 11'h0ad, 1, 32'h14, 32'hc0, 16);
        log_q.delete();
        kick(20'h1_0000);
        wait_tc(2);
        chk(log_q[0], 32'h14);
        $display("test arbitration done");
        setup(5, 11'h1a3, 2, 32'h20, 32'hc4, 1);
        log_q.delete();
        kick(20'h0_0002);
        bus(0, {3'h5, 5'h14}, 1);
        kick(20'h0_0002);
        kick(20'h0_0002);
        bus(0, {3'h5, 5'h04}, 1);
        chk(log_q[2], 32'h20);
        err_addr <= 8'h30;
        setup(6, 11'h4a1, 2, 32'h30, 32'hc8, 31);
        repeat (6) @(posedge core_clk);
        bus(0, {3'h6, 5'h14}, 4);
        bus(0, {3'h6, 5'h00}, 32'h0000_04a0);
        chk(ch_irq[6], 1);
        bus(1, {3'h6, 5'h14}, 7);
        repeat (2) @(posedge core_clk);
        chk(ch_irq[6], 0);
        $display("test circular and error done");
        complete_run;
    end
endmodule // testbench
